//--- interrupt_speed_reset_control.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module interrupt_speed_reset_control import isr_ctl_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Fuse words
   input wire logic [7:0] fuse_word_zero,
   input wire logic [7:0] fuse_word_one,
   // Reset sources
   input wire logic rst_pin_n,
   input wire logic brownout_low,
   input wire logic wdt_overflow,
   input wire logic dbg_target_reset,
   // Interrupt sources
   input wire logic [N_SRC-1:0] src_hw_set,
   input wire logic [N_SRC-1:0] periph_enable,
   // Pipeline
   input wire logic prog_mem_op,
   input wire logic reti_exec,
   input wire logic [2:0] reti_opts,
   input wire logic [15:0] reti_pc_next,
   input wire logic [7:0] w_value,
   output logic instr_block,
   output logic irq_take,
   output logic resume,
   output logic [15:0] vector_addr,
   // Reset and clock control
   output logic cpu_reset,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic [7:0] speed_out,
   output logic core_clock_run
);
   rst_ctl_if rc ();

   seq_e state_reg, state_next;
   logic [7:0] speed_reg, int_speed_reg, shadow_reg;
   logic [7:0] vec_hi_reg, vec_lo_reg, t0_reg;
   logic gie_reg;
   logic [N_SRC-1:0] flag_reg, irq_en_reg;
   logic [2:0] block_cnt_reg;
   logic [11:0] lat_cnt_reg;
   logic [1:0] ret_cnt_reg;
   logic port_d1_reg, port_d2_reg;
   logic cpu_reset_d_reg;
   logic [15:0] pc_value_reg;
   logic [7:0] rdata_reg;
   logic port_pend, port_req, other_req, irq_req;
   logic start, take_reti, stopped, wake;
   logic [11:0] lat_total;
   logic wr_speed, wr_int_speed, wr_vec_hi, wr_vec_lo, wr_t0, wr_status, wr_flags, wr_irq_en;

   function automatic logic [11:0] wake_cycles(input logic [2:0] code);
      wake_cycles = WAKE_UNIT_CYC << code;
   endfunction

   assign rc.wd_req = wdt_overflow;
   assign rc.dbg_req = dbg_target_reset;
   // Fuse fields come straight from the fuse inputs and have no write path
   assign rc.wud_code = fuse_word_zero[WUDX_HI:WUDX_LO];
   assign rc.bor_code = fuse_word_one[BOR_HI:BOR_LO];

   reset_sequencer u_reset (
      .clock(clock),
      .arst_n(arst_n),
      .rst_pin_n(rst_pin_n),
      .brownout_low(brownout_low),
      .rc(rc)
   );

   assign cpu_reset = rc.cpu_reset;

   assign wr_speed = reg_wr && reg_addr == ADDR_SPEED;
   assign wr_int_speed = reg_wr && reg_addr == ADDR_INT_SPEED;
   assign wr_vec_hi = reg_wr && reg_addr == ADDR_VEC_HI;
   assign wr_vec_lo = reg_wr && reg_addr == ADDR_VEC_LO;
   assign wr_t0 = reg_wr && reg_addr == ADDR_T0;
   assign wr_status = reg_wr && reg_addr == ADDR_STATUS;
   assign wr_flags = reg_wr && reg_addr == ADDR_FLAGS;
   assign wr_irq_en = reg_wr && reg_addr == ADDR_IRQ_EN;

   // Interrupt request path
   assign port_pend = flag_reg[SRC_PORT] && irq_en_reg[SRC_PORT];
   assign port_req = fuse_word_one[SYNC_BIT] ? port_pend : port_d2_reg;
   assign other_req = |(flag_reg[N_SRC-1:1] & irq_en_reg[N_SRC-1:1]);
   assign irq_req = gie_reg && (port_req || other_req);
   assign stopped = speed_reg[SPD_DIV_HI:0] == SPD_STOP_DIV;
   assign start = state_reg == SEQ_IDLE && irq_req && !cpu_reset && !instr_block && !prog_mem_op;
   assign take_reti = state_reg == SEQ_ISR && reti_exec;
   // A stopped clock is restarted by port or real-time events without reset
   assign wake = stopped && !gie_reg && !cpu_reset &&
                 ((flag_reg[SRC_PORT] && irq_en_reg[SRC_PORT]) ||
                  (flag_reg[SRC_RTT] && irq_en_reg[SRC_RTT]));

   always_comb begin
      lat_total = IRQ_LAT_CYC;
      if (speed_reg[SPD_SRC_HI:SPD_SRC_LO] != int_speed_reg[SPD_SRC_HI:SPD_SRC_LO]) begin
         lat_total = lat_total + SRC_SWITCH_CYC;
      end
      if (int_speed_reg[SPD_OSC_BIT] && !speed_reg[SPD_OSC_BIT]) begin
         lat_total = lat_total + wake_cycles(fuse_word_zero[WUDX_HI:WUDX_LO]);
      end else if (int_speed_reg[SPD_PLL_BIT] && !speed_reg[SPD_PLL_BIT]) begin
         lat_total = lat_total + wake_cycles(fuse_word_zero[WUDP_HI:WUDP_LO]);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         port_d1_reg <= 1'b0;
         port_d2_reg <= 1'b0;
      end else begin
         port_d1_reg <= port_pend;
         port_d2_reg <= port_d1_reg;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         block_cnt_reg <= 3'h0;
      end else if (cpu_reset) begin
         block_cnt_reg <= 3'h0;
      end else if (prog_mem_op) begin
         block_cnt_reg <= PROG_BLOCK_CYC;
      end else if (block_cnt_reg != 3'h0) begin
         block_cnt_reg <= block_cnt_reg - 3'h1;
      end
   end

   assign instr_block = block_cnt_reg != 3'h0;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SEQ_IDLE: begin
            if (start) begin
               state_next = SEQ_ENTRY;
            end
         end
         SEQ_ENTRY: begin
            if (lat_cnt_reg == 12'h001) begin
               state_next = SEQ_ISR;
            end
         end
         SEQ_ISR: begin
            if (reti_exec) begin
               state_next = SEQ_RETURN;
            end
         end
         SEQ_RETURN: begin
            if (ret_cnt_reg == 2'h1) begin
               state_next = SEQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SEQ_IDLE;
      end else if (cpu_reset) begin
         state_reg <= SEQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lat_cnt_reg <= 12'h000;
      end else if (start) begin
         lat_cnt_reg <= lat_total;
      end else if (state_reg == SEQ_ENTRY) begin
         lat_cnt_reg <= lat_cnt_reg - 12'h001;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ret_cnt_reg <= 2'h0;
      end else if (take_reti) begin
         ret_cnt_reg <= RETI_EXEC_CYC + RETI_PIPE_CYC;
      end else if (state_reg == SEQ_RETURN) begin
         ret_cnt_reg <= ret_cnt_reg - 2'h1;
      end
   end

   assign irq_take = state_reg == SEQ_ENTRY && lat_cnt_reg == 12'h001;
   assign resume = state_reg == SEQ_RETURN && ret_cnt_reg == 2'h1;
   assign vector_addr = {vec_hi_reg, vec_lo_reg};

   // Speed control and its shadow copy
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         speed_reg <= SPEED_RESET;
         shadow_reg <= SPEED_RESET;
      end else if (cpu_reset) begin
         speed_reg <= SPEED_RESET;
         shadow_reg <= SPEED_RESET;
      end else if (start) begin
         shadow_reg <= speed_reg;
         speed_reg <= int_speed_reg;
      end else if (take_reti && reti_opts[2]) begin
         speed_reg <= shadow_reg;
      end else if (wake) begin
         speed_reg <= int_speed_reg;
      end else if (wr_speed) begin
         speed_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         int_speed_reg <= 8'h00;
      end else if (cpu_reset) begin
         int_speed_reg <= 8'h00;
      end else if (wr_int_speed) begin
         int_speed_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         vec_hi_reg <= 8'h00;
         vec_lo_reg <= 8'h00;
      end else if (cpu_reset) begin
         vec_hi_reg <= 8'h00;
         vec_lo_reg <= 8'h00;
      end else if (take_reti && reti_opts[1]) begin
         vec_hi_reg <= reti_pc_next[15:8];
         vec_lo_reg <= reti_pc_next[7:0];
      end else begin
         if (wr_vec_hi) begin
            vec_hi_reg <= reg_wdata;
         end
         if (wr_vec_lo) begin
            vec_lo_reg <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_reg <= 8'h00;
      end else if (cpu_reset) begin
         t0_reg <= 8'h00;
      end else if (take_reti && reti_opts[0]) begin
         t0_reg <= t0_reg + w_value;
      end else if (wr_t0) begin
         t0_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gie_reg <= 1'b0;
      end else if (cpu_reset) begin
         gie_reg <= 1'b0;
      end else if (start) begin
         gie_reg <= 1'b0;
      end else if (take_reti) begin
         gie_reg <= 1'b1;
      end else if (wr_status) begin
         gie_reg <= reg_wdata[STAT_GIE];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_en_reg <= '0;
      end else if (cpu_reset) begin
         irq_en_reg <= '0;
      end else if (wr_irq_en) begin
         irq_en_reg <= reg_wdata[N_SRC-1:0];
      end
   end

   // Flags keep being set while the core clock is stopped; hardware set wins over a write
   for (genvar i = 0; i < N_SRC; i++) begin : g_flag
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            flag_reg[i] <= 1'b0;
         end else if (cpu_reset) begin
            flag_reg[i] <= 1'b0;
         end else begin
            flag_reg[i] <= (wr_flags ? reg_wdata[i] : flag_reg[i]) ||
                           (src_hw_set[i] && periph_enable[i]);
         end
      end
      a_disabled_no_set: assert property (@(posedge clock) disable iff (!arst_n)
         (!periph_enable[i] && !flag_reg[i] && !wr_flags) |=> !flag_reg[i])
         else $error("disabled peripheral set its flag");
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cpu_reset_d_reg <= 1'b1;
         pc_value_reg <= RESET_VECTOR;
      end else begin
         cpu_reset_d_reg <= cpu_reset;
         if (cpu_reset) begin
            pc_value_reg <= RESET_VECTOR;
         end
      end
   end

   assign pc_load = cpu_reset_d_reg && !cpu_reset;
   assign pc_value = pc_value_reg;
   assign speed_out = speed_reg;
   assign core_clock_run = !cpu_reset && !stopped;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SPEED: rdata_reg <= speed_reg;
            ADDR_INT_SPEED: rdata_reg <= int_speed_reg;
            ADDR_SHADOW: rdata_reg <= shadow_reg;
            ADDR_VEC_HI: rdata_reg <= vec_hi_reg;
            ADDR_VEC_LO: rdata_reg <= vec_lo_reg;
            ADDR_T0: rdata_reg <= t0_reg;
            ADDR_STATUS: begin
               rdata_reg <= 8'h00;
               rdata_reg[STAT_GIE] <= gie_reg;
               rdata_reg[STAT_WD] <= rc.wd_cause;
               rdata_reg[STAT_BO] <= rc.bo_cause;
               rdata_reg[STAT_STOP] <= stopped;
            end
            ADDR_FLAGS: rdata_reg <= {{(8-N_SRC){1'b0}}, flag_reg};
            ADDR_IRQ_EN: rdata_reg <= {{(8-N_SRC){1'b0}}, irq_en_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_reg;

   a_entry_shadow: assert property (@(posedge clock) disable iff (!arst_n)
      start |=> shadow_reg == $past(speed_reg) && speed_reg == $past(int_speed_reg))
      else $error("speed not saved and replaced on entry");
   a_entry_base_latency: assert property (@(posedge clock) disable iff (!arst_n)
      (start && lat_total == IRQ_LAT_CYC) |-> !irq_take ##1 !irq_take ##1 !irq_take ##1 irq_take)
      else $error("same-source latency not 3 cycles");
   a_entry_gie_clear: assert property (@(posedge clock) disable iff (!arst_n)
      start |=> !gie_reg throughout (state_reg == SEQ_ENTRY)[*1])
      else $error("global enable not cleared on entry");
   a_reti_resume_time: assert property (@(posedge clock) disable iff (!arst_n || cpu_reset)
      take_reti |=> gie_reg && !resume ##1 !resume ##1 resume)
      else $error("return did not resume after 3 cycles");
   a_reti_vector: assert property (@(posedge clock) disable iff (!arst_n || cpu_reset)
      (take_reti && reti_opts[1]) |=> vector_addr == $past(reti_pc_next))
      else $error("vector not updated on return");
   a_reti_timer_add: assert property (@(posedge clock) disable iff (!arst_n || cpu_reset)
      (take_reti && reti_opts[0]) |=> t0_reg == 8'($past(t0_reg) + $past(w_value)))
      else $error("timer zero not advanced by working register");
   a_block_length: assert property (@(posedge clock) disable iff (!arst_n || cpu_reset)
      prog_mem_op |=> instr_block[*4]) else $error("program-memory block not 4 cycles");
endmodule
`default_nettype wire

//--- isr_ctl_pkg.sv
// Notes on behaviour
// - Port edge interrupt gets two extra sync cycles when fuse sync bit is 0.
// - Program-memory read/write blocks execution 4 cycles; latency may grow up to 3. Here entry can be held off up to 5 cycles.
// - Interrupt entry copies speed to shadow, then loads speed from interrupt speed.
// - Same clock source: latency is a fixed 3 cycles of the new clock.
// - Source switch adds up to one slower-clock cycle to the normal latency.
// - PLL or oscillator re-enable adds its fuse-selected wake-up delay.
// - Return option bit 2 restores the pre-interrupt speed from the shadow.
// - Return option bit 1 writes incremented PC into vector high and low.
// - Return option bit 0 adds working register to timer zero count.
// - Return takes 1 execute cycle plus 2 pipeline cycles before mainline resumes.
// - Disabled peripheral cannot set its flag; software-set flags still interrupt.
// - Interrupt logic keeps running while the system clock is stopped.
// - Port or real-time interrupt wakes without reset; other wake sources reset.
// - Every reset source loads the program counter with the reset vector.
// - Reset has a 10-bit startup timer and a latch set at power-up.
// - Timer starts once reset pin is high; timeout clears latch.
// - Watchdog cause flag cleared on reset unless watchdog caused it.
// - Brown-out cause flag cleared on reset unless brown-out caused it.
// - Oscillator wake-up fuse field selects the startup period length.
// - Brown-out holds reset while low; level code 111 disables detection.
// - Fuse bits are constant and cannot be written by software.
// - Global enable clears on interrupt entry and sets on return.
package isr_ctl_pkg;
   localparam logic [3:0] ADDR_SPEED = 4'h0;
   localparam logic [3:0] ADDR_INT_SPEED = 4'h1;
   localparam logic [3:0] ADDR_SHADOW = 4'h2;
   localparam logic [3:0] ADDR_VEC_HI = 4'h3;
   localparam logic [3:0] ADDR_VEC_LO = 4'h4;
   localparam logic [3:0] ADDR_T0 = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_FLAGS = 4'h7;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h8;
   localparam logic [7:0] SPEED_RESET = 8'h93;
   localparam logic [15:0] RESET_VECTOR = 16'hfff0;
   localparam int SPD_DIV_HI = 3;
   localparam int SPD_SRC_HI = 5;
   localparam int SPD_SRC_LO = 4;
   localparam int SPD_PLL_BIT = 6;
   localparam int SPD_OSC_BIT = 7;
   localparam logic [3:0] SPD_STOP_DIV = 4'hf;
   localparam int WUDX_HI = 2;
   localparam int WUDX_LO = 0;
   localparam int WUDP_HI = 5;
   localparam int WUDP_LO = 3;
   localparam int BOR_HI = 2;
   localparam int BOR_LO = 0;
   localparam int SYNC_BIT = 3;
   localparam logic [2:0] BOR_DISABLED = 3'h7;
   localparam int STAT_GIE = 0;
   localparam int STAT_WD = 1;
   localparam int STAT_BO = 2;
   localparam int STAT_STOP = 3;
   localparam int N_SRC = 4;
   localparam int SRC_PORT = 0;
   localparam int SRC_RTT = 1;
   localparam logic [11:0] IRQ_LAT_CYC = 12'h003;
   localparam logic [2:0] PROG_BLOCK_CYC = 3'h4;
   localparam logic [1:0] RETI_EXEC_CYC = 2'h1;
   localparam logic [1:0] RETI_PIPE_CYC = 2'h2;
   localparam logic [11:0] SRC_SWITCH_CYC = 12'h008;
   localparam logic [11:0] WAKE_UNIT_CYC = 12'h010;
   localparam logic [9:0] STARTUP_BASE = 10'h008;
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_ENTRY = 4'b0010,
      SEQ_ISR = 4'b0100,
      SEQ_RETURN = 4'b1000
   } seq_e;
endpackage

//--- rst_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rst_ctl_if;
   logic wd_req;
   logic dbg_req;
   logic [2:0] wud_code;
   logic [2:0] bor_code;
   logic cpu_reset;
   logic wd_cause;
   logic bo_cause;
   modport seq (input wd_req, input dbg_req, input wud_code, input bor_code,
                output cpu_reset, output wd_cause, output bo_cause);
   modport ctl (output wd_req, output dbg_req, output wud_code, output bor_code,
                input cpu_reset, input wd_cause, input bo_cause);
endinterface
`default_nettype wire

//--- reset_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer import isr_ctl_pkg::*; (
   // Clock and power-on reset
   input wire logic clock,
   input wire logic arst_n,
   // Asynchronous reset sources
   input wire logic rst_pin_n,
   input wire logic brownout_low,
   // Control side
   rst_ctl_if.seq rc
);
   logic pin_s1, pin_s2, bo_s1, bo_s2;
   logic latch_reg;
   logic [9:0] timer_reg;
   logic wd_reg, bo_reg;
   logic bo_active, hold;
   logic [9:0] limit;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         bo_s1 <= 1'b0;
         bo_s2 <= 1'b0;
      end else begin
         pin_s1 <= rst_pin_n;
         pin_s2 <= pin_s1;
         bo_s1 <= brownout_low;
         bo_s2 <= bo_s1;
      end
   end

   assign bo_active = bo_s2 && (rc.bor_code != BOR_DISABLED);
   assign hold = !pin_s2 || bo_active || rc.wd_req || rc.dbg_req;
   assign limit = (STARTUP_BASE << rc.wud_code) - 10'h001;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         latch_reg <= 1'b1;
      end else if (hold) begin
         latch_reg <= 1'b1;
      end else if (latch_reg && timer_reg == limit) begin
         latch_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         timer_reg <= 10'h000;
      end else if (hold || !latch_reg || timer_reg == limit) begin
         timer_reg <= 10'h000;
      end else begin
         timer_reg <= timer_reg + 10'h001;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wd_reg <= 1'b0;
         bo_reg <= 1'b0;
      end else if (hold) begin
         wd_reg <= rc.wd_req;
         bo_reg <= bo_active && !rc.wd_req;
      end
   end

   assign rc.cpu_reset = latch_reg;
   assign rc.wd_cause = wd_reg;
   assign rc.bo_cause = bo_reg;

   a_hold_sets_latch: assert property (@(posedge clock) disable iff (!arst_n)
      hold |=> latch_reg) else $error("reset latch not set by active source");
   a_timeout_release: assert property (@(posedge clock) disable iff (!arst_n)
      (latch_reg && !hold && timer_reg == limit) |=> !latch_reg && timer_reg == 10'h000)
      else $error("latch not released at timeout");
   a_wd_cause_flag: assert property (@(posedge clock) disable iff (!arst_n)
      rc.wd_req |=> wd_reg && !bo_reg) else $error("watchdog cause not recorded");
endmodule
`default_nettype wire

//--- pipeline_model.sv
`timescale 1ns/100ps
`default_nettype none
module pipeline_model (
   // Clock
   input wire logic clock,
   // Return instruction
   output logic reti_exec,
   output logic [2:0] reti_opts,
   output logic [15:0] reti_pc_next,
   output logic [7:0] w_value
);
   initial begin
      reti_exec = 1'b0;
      reti_opts = 3'h0;
      reti_pc_next = 16'h0000;
      w_value = 8'h00;
   end
   // Operands only mean something beside the strobe, so they are scrambled after it
   task automatic issue(input logic [2:0] o, input logic [15:0] p, input logic [7:0] w);
      @(posedge clock);
      reti_exec <= 1'b1;
      reti_opts <= o;
      reti_pc_next <= p;
      w_value <= w;
      @(posedge clock);
      reti_exec <= 1'b0;
      reti_opts <= ~o;
      reti_pc_next <= ~p;
      w_value <= ~w;
   endtask
endmodule
`default_nettype wire

//--- interrupt_speed_reset_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_speed_reset_control_test import isr_ctl_pkg::*;;
   localparam logic [2:0][7:0] MAIN = {8'h13, 8'h93, 8'h93};
   localparam logic [2:0][7:0] ISPD = {8'h93, 8'ha1, 8'h91};
   localparam logic [2:0][7:0] LAT = {8'd19, 8'd11, 8'd5};
   localparam logic [2:0][7:0] EN = {8'h04, 8'h04, 8'h01};
   localparam logic [2:0][2:0] OPTS = {3'b101, 3'b000, 3'b111};
   localparam logic [2:0][15:0] PC = {16'h5678, 16'h4321, 16'h1234};
   localparam logic [2:0][7:0] WV = {8'h10, 8'h77, 8'h25};
   logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rst_pin_n = 0;
   logic brownout_low = 0, wdt_overflow = 0, dbg_target_reset = 0, prog_mem_op = 0;
   logic [3:0] reg_addr = 0, src_hw_set = 0, periph_enable = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, speed_out, w_value, rd_val, t0_exp = 0;
   logic instr_block, irq_take, resume, cpu_reset, pc_load, core_clock_run, reti_exec;
   logic [2:0] reti_opts;
   logic [15:0] vector_addr, pc_value, reti_pc_next, vec_exp = 0;
   int failures = 0, checks = 0;
   always #4 clock = ~clock;
   interrupt_speed_reset_control dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fuse_word_zero(8'h00), .fuse_word_one(8'h00), .rst_pin_n(rst_pin_n),
      .brownout_low(brownout_low), .wdt_overflow(wdt_overflow), .dbg_target_reset(dbg_target_reset),
      .src_hw_set(src_hw_set), .periph_enable(periph_enable), .prog_mem_op(prog_mem_op), .reti_exec(reti_exec),
      .reti_opts(reti_opts), .reti_pc_next(reti_pc_next), .w_value(w_value),
      .instr_block(instr_block), .irq_take(irq_take), .resume(resume), .vector_addr(vector_addr),
      .cpu_reset(cpu_reset), .pc_load(pc_load), .pc_value(pc_value), .speed_out(speed_out),
      .core_clock_run(core_clock_run));
   pipeline_model pm (.clock(clock), .reti_exec(reti_exec), .reti_opts(reti_opts),
      .reti_pc_next(reti_pc_next), .w_value(w_value));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Counts cycles until the chosen event: 0 entry, 1 resume, 2 reset release
   task automatic wait_ev(input int k, output int n);
      n = 0;
      #1;
      while (n < 200 && !(k == 0 ? irq_take === 1'b1 : k == 1 ? resume === 1'b1 : cpu_reset === 1'b0)) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask
   task automatic release_check(output int n);
      wait_ev(2, n);
      chk(16'(n < 20), 1, "release");
      chk(pc_load, 1, "pc load");
      chk(pc_value, RESET_VECTOR, "pc value");
      chk(speed_out, SPEED_RESET, "speed");
   endtask
   task automatic test_startup;
      int n;
      repeat (30) @(posedge clock);
      #1 chk(cpu_reset, 1, "held");
      @(posedge clock);
      rst_pin_n <= 1'b1;
      release_check(n);
      rd(4'hf);
      chk(rd_val, 0, "unmapped");
      $display("startup test done");
   endtask
   task automatic test_irq;
      int n;
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_SPEED, MAIN[i]);
         wr(ADDR_INT_SPEED, ISPD[i]);
         wr(ADDR_IRQ_EN, EN[i]);
         wr(ADDR_STATUS, 8'h01);
         wr(ADDR_FLAGS, EN[i]);
         wait_ev(0, n);
         chk(n[15:0], LAT[i], "latency");
         chk(speed_out, ISPD[i], "int speed");
         rd(ADDR_SHADOW);
         chk(rd_val, MAIN[i], "shadow");
         rd(ADDR_STATUS);
         chk(rd_val, 0, "gie clear");
         wr(ADDR_FLAGS, 8'h00);
         pm.issue(OPTS[i], PC[i], WV[i]);
         wait_ev(1, n);
         chk(n[15:0], 2, "resume");
         if (OPTS[i][1]) vec_exp = PC[i];
         if (OPTS[i][0]) t0_exp += WV[i];
         chk(speed_out, OPTS[i][2] ? MAIN[i] : ISPD[i], "restore");
         chk(vector_addr, vec_exp, "vector");
         rd(ADDR_T0);
         chk(rd_val, t0_exp, "t0");
         rd(ADDR_STATUS);
         chk(rd_val, 1, "gie set");
      end
      $display("interrupt test done");
   endtask
   task automatic test_stop_wake;
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_IRQ_EN, 8'h02);
      wr(ADDR_INT_SPEED, 8'h91);
      wr(ADDR_SPEED, 8'h9f);
      #1 chk(core_clock_run, 0, "stopped");
      wr(ADDR_FLAGS, 8'h02);
      @(posedge clock);
      #1 chk(speed_out, 8'h91, "wake");
      chk(cpu_reset, 0, "no reset");
      wr(ADDR_FLAGS, 8'h00);
      $display("stop wake test done");
   endtask
   task automatic test_block_set;
      @(posedge clock);
      prog_mem_op <= 1'b1;
      src_hw_set <= 4'h4;
      @(posedge clock);
      prog_mem_op <= 1'b0;
      src_hw_set <= 4'h0;
      for (int k = 0; k < 5; k++) begin
         #1 chk(instr_block, 16'(k < 4), "block");
         @(posedge clock);
      end
      rd(ADDR_FLAGS);
      chk(rd_val, 0, "disabled set");
      @(posedge clock);
      periph_enable <= 4'h4;
      src_hw_set <= 4'h4;
      @(posedge clock);
      src_hw_set <= 4'h0;
      rd(ADDR_FLAGS);
      chk(rd_val, 4, "enabled set");
      $display("block and flag test done");
   endtask
   task automatic test_resets;
      int n;
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         if (i == 0) wdt_overflow <= 1'b1;
         else if (i == 1) brownout_low <= 1'b1;
         else dbg_target_reset <= 1'b1;
         @(posedge clock);
         wdt_overflow <= 1'b0;
         dbg_target_reset <= 1'b0;
         repeat (4) @(posedge clock);
         #1 chk(cpu_reset, 1, "reset taken");
         @(posedge clock);
         brownout_low <= 1'b0;
         release_check(n);
         rd(ADDR_STATUS);
         chk(rd_val, i == 0 ? 2 : i == 1 ? 4 : 0, "cause");
      end
      $display("reset test done");
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      failures++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      test_startup();
      test_irq();
      test_stop_wake();
      test_block_set();
      test_resets();
      final_report();
   end
endmodule
`default_nettype wire
